// ---- bench/pgmp_msg_port_props.sv ----
// pin-level assertions for the gage message port
`timescale 1ns/1ns
module pgmp_msg_port_props #(
   parameter int PULSE_CYC = 20,
   parameter int GAP_CYC   = 30
) (
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic [5:0] command_bits,
   input wire logic       command_strobe_line,
   input wire logic [4:0] reply_code,
   input wire logic       reply_valid_line,
   input wire logic       end_gage_pulse,
   input wire logic [3:0] feedback_clear,
   input wire logic [2:0] machine_id,
   input wire logic [3:0] setup_sel,
   input wire logic       position_reset
);
   import pgmp_pkg::*;
   logic [5:0] c;
   int         hi_q;
   int         lo_q;
   assign c = command_bits;
   // lo_q starts at the gap so the first pulse is not flagged
   always_ff @(posedge core_clk) begin
      hi_q <= (reset || !reply_valid_line) ? 0 : hi_q + 1;
      lo_q <= reset ? GAP_CYC : (reply_valid_line ? 0 : lo_q + 1);
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   chk_fb_one_hot: assert property ($rose(command_strobe_line) &&
      c inside {[6'h12:6'h15]} |=>
      feedback_clear == 4'h1 << ($past(c) - 6'h12)) else $error("fb clear");
   chk_mid_record: assert property ($rose(command_strobe_line) &&
      c inside {[6'h16:6'h1D]} |=> machine_id == 3'($past(c) - 6'h16))
      else $error("machine id");
   chk_setup_pick: assert property ($rose(command_strobe_line) &&
      c inside {[6'h25:6'h2D]} |=> setup_sel == 4'($past(c) - 6'h25))
      else $error("setup select");
   chk_pos_pulse: assert property ($rose(command_strobe_line) &&
      c inside {[6'h1E:6'h21]} |=> position_reset ##1 !position_reset)
      else $error("position reset");
   chk_end_pulse: assert property ($rose(command_strobe_line) &&
      c == 6'h09 |=> end_gage_pulse) else $error("end gage pulse");
   chk_unknown_drop: assert property ($rose(command_strobe_line) &&
      c inside {6'h00, [6'h0F:6'h11], [6'h2E:6'h3F]} |=> $stable(machine_id)
      && $stable(setup_sel) && feedback_clear == 4'h0 && !position_reset
      && !end_gage_pulse) else $error("unassigned code acted on");
   chk_code_ready: assert property ($rose(reply_valid_line) |->
      $past(reply_code, 9) == reply_code) else $error("code not settled");
   chk_pulse_width: assert property ($fell(reply_valid_line) &&
      !$past(reset) |-> hi_q == PULSE_CYC) else $error("pulse width");
   chk_pulse_gap: assert property ($rose(reply_valid_line) |->
      lo_q >= GAP_CYC) else $error("pulse spacing");
endmodule
bind pgmp_msg_port pgmp_msg_port_props #(.PULSE_CYC(PULSE_CYC),
   .GAP_CYC(GAP_CYC)) u_props (.core_clk, .reset, .command_bits,
   .command_strobe_line, .reply_code, .reply_valid_line, .end_gage_pulse,
   .feedback_clear, .machine_id, .setup_sel, .position_reset);

// ---- bench/pgmp_plc_model.sv ----
// controller model driving command lines and strobe
`timescale 1ns/1ns
module pgmp_plc_model (
   input wire logic       core_clk,
   input wire logic       go,
   input wire logic [5:0] code,
   input wire logic       wait_rpy,
   input wire logic       reply_valid_line,
   output logic [5:0]     command_bits,
   output logic           command_strobe_line,
   output logic           busy
);
   int n;
   initial begin
      {command_bits, command_strobe_line, busy} = 8'h00;
      forever begin
         @(posedge core_clk);
         if (go) begin
            #1 busy = 1;
            // data settled a cycle before strobe
            command_bits = code;
            @(posedge core_clk);
            #1 command_strobe_line = 1;
            n = 0;
            // hold until the reply strobe rises, or for 8 cycles when wait_rpy is low
            while (n < 900 && (wait_rpy ? !reply_valid_line : n < 8)) begin
               @(posedge core_clk);
               n++;
            end
            #1 command_strobe_line = 0;
            @(posedge core_clk);
            // released lines no longer show the code
            #1 command_bits = ~code;
            busy = 0;
         end
      end
   end
endmodule

// ---- bench/tb_pgmp_msg_port.sv ----
// self-checking bench for the gage message port
`timescale 1ns/1ns
module tb_pgmp_msg_port;
   import pgmp_pkg::*;
   logic        core_clk, reset, fault_msg, gage_done, rr_study, go, busy;
   logic        class_enable, adverse_event, wait_rpy, reply_valid_line;
   logic        command_strobe_line, gaging, gage_auto, end_gage_pulse;
   logic        mastering, verifying, position_reset;
   logic        rv_q = 1'b0;
   logic [5:0]  command_bits, code;
   logic [1:0]  gage_status, active_gage;
   logic [4:0]  part_class, reply_code;
   logic [3:0]  feedback_clear, setup_sel;
   logic [2:0]  machine_id;
   logic [4:0]  exp_q[$];
   logic [31:0] rnd = 32'h18B5;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   pgmp_msg_port #(.PULSE_CYC(20), .GAP_CYC(30)) u_dut (.core_clk, .reset,
      .command_bits, .command_strobe_line, .fault_msg, .gage_done,
      .gage_status, .rr_study, .class_enable, .part_class, .adverse_event,
      .reply_code, .reply_valid_line, .active_gage, .gage_auto, .gaging,
      .end_gage_pulse, .mastering, .verifying, .feedback_clear, .machine_id,
      .setup_sel, .position_reset);
   pgmp_plc_model u_plc (.core_clk, .go, .code, .wait_rpy, .reply_valid_line,
      .command_bits, .command_strobe_line, .busy);
   task automatic chk(input logic [5:0] g, input logic [5:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      end
   endtask
   task automatic stop_test;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      core_clk = 0;
      forever #4 core_clk = ~core_clk;
   end
   // a reply strobe takes the oldest expected code
   always @(posedge core_clk) begin
      rv_q <= reply_valid_line;
      if (reply_valid_line === 1'b1 && rv_q === 1'b0) begin
         if (exp_q.size() == 0) chk(6'h3F, 6'(reply_code));
         else chk(6'(reply_code), 6'(exp_q.pop_front()));
      end
      cyc++;
      if (cyc == 10000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic send(input logic [5:0] c, input logic w);
      @(posedge core_clk);
      #1 go = 1;
      code = c;
      wait_rpy = w;
      @(posedge core_clk);
      #1 go = 0;
   endtask
   // waits out the command hold and any pending replies
   task automatic wt;
      int k;
      k = 0;
      @(posedge core_clk);
      while ((busy !== 1'b0 || exp_q.size() != 0 ||
              reply_valid_line !== 1'b0) && k < 900) begin
         @(posedge core_clk);
         k++;
      end
      #1;
   endtask
   task automatic gage(input logic [5:0] c);
      send(c, 1'b1);
      repeat (4) @(posedge core_clk);
      #1 chk(6'(gaging), 6'h01);
      gage_done = 1;
      @(posedge core_clk);
      #1 gage_done = 0;
      wt();
      chk(6'(gaging), 6'h00);
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   initial begin
      {reset, fault_msg, gage_done, rr_study, class_enable} = 5'h10;
      {adverse_event, go, wait_rpy, code, gage_status, part_class} = '0;
      repeat (6) @(posedge core_clk);
      #1 reset = 0;
      exp_q.push_back(RPY_ACK);
      fault_msg = 1;
      wt();
      fault_msg = 0;
      exp_q.push_back(RPY_SHUTDOWN);
      adverse_event = 1;
      wt();
      adverse_event = 0;
      class_enable = 1;
      for (int g = 0; g < 4; g++) begin
         rnd = xs(rnd);
         gage_status = rnd[1:0];
         part_class = (g == 3) ? 5'h1F : rnd[8:4];
         exp_q.push_back(gage_status == 2'h0 ? RPY_ACCEPT :
            (gage_status == 2'h1 ? RPY_REJECT : RPY_REWORK));
         exp_q.push_back(part_class inside {[5'h01:CLASS_MAX]} ?
            part_class : RPY_CLASS_ERR);
         gage(6'(2 * g + 2));
         chk(6'({active_gage, gage_auto}), 6'(2 * g + 1));
      end
      class_enable = 0;
      rr_study = 1;
      exp_q.push_back(RPY_SORT);
      gage(6'h04);
      rr_study = 0;
      exp_q.push_back(RPY_END);
      gage(6'h05);
      chk(6'({active_gage, gage_auto}), 6'h04);
      send(6'h0B, 1'b0);
      wt();
      chk(6'(mastering), 6'h01);
      send(6'h0E, 1'b0);
      wt();
      chk(6'(mastering), 6'h00);
      send(6'h0D, 1'b0);
      wt();
      exp_q.push_back(RPY_END);
      gage(6'h08);
      send(6'h22, 1'b0);
      wt();
      chk(6'(verifying), 6'h01);
      for (int c = 0; c < 64; c++) begin
         if (c >= 1 && c <= 14 && c != 9) continue;
         send(6'(c), 1'b0);
         wt();
         if (c >= 22 && c <= 29) chk(6'(machine_id), 6'(c - 22));
         if (c >= 37 && c <= 45) chk(6'(setup_sel), 6'(c - 37));
      end
      chk(6'(exp_q.size()), 6'h00);
      stop_test();
   end
endmodule

// ---- pkg/pgmp_pkg.sv ----
// constants and types for the parallel gage message port
// Overview of operation
// - commands act only while strobe line asserted
// - start gage n: manual 2n-1, auto 2n
// - code 9 end, 10-13 master, 14 abort
// - reset feedback codes 18-21; 15-17 unassigned
// - reset position codes 30 to 33
// - auto verification codes 34 to 36
// - reset feedback clears addressed gage offset
// - machine identity recorded for feedback use
// - reset position returns sequence to start
// - load setup switches active configuration
// - valid line only after reply code stable
// - reply codes: 1,2,3,4,5,6 and 31
// - fault message answered with acknowledge
// - end gage reply after manual or master start
// - auto start gets part status or sort
// - class sent on second valid strobe
// - shutdown sent unsolicited on adverse event
// - commands captured on strobe rising edge
// - valid pulses spaced at least one millisecond
package pgmp_pkg;
   localparam int CMD_W = 6;
   localparam int RPY_W = 5;
   localparam logic [5:0] CMD_START_LO  = 6'h01;
   localparam logic [5:0] CMD_START_HI  = 6'h08;
   localparam logic [5:0] CMD_END       = 6'h09;
   localparam logic [5:0] CMD_MAST_LO   = 6'h0A;
   localparam logic [5:0] CMD_MAST_HI   = 6'h0D;
   localparam logic [5:0] CMD_ABORT     = 6'h0E;
   localparam logic [5:0] CMD_FB_LO     = 6'h12;
   localparam logic [5:0] CMD_FB_HI     = 6'h15;
   localparam logic [5:0] CMD_MID_LO    = 6'h16;
   localparam logic [5:0] CMD_MID_HI    = 6'h1D;
   localparam logic [5:0] CMD_POS_LO    = 6'h1E;
   localparam logic [5:0] CMD_POS_HI    = 6'h21;
   localparam logic [5:0] CMD_VER_LO    = 6'h22;
   localparam logic [5:0] CMD_VER_HI    = 6'h24;
   localparam logic [5:0] CMD_SETUP_LO  = 6'h25;
   localparam logic [5:0] CMD_SETUP_HI  = 6'h2D;
   localparam logic [4:0] RPY_ACK       = 5'h01;
   localparam logic [4:0] RPY_END       = 5'h02;
   localparam logic [4:0] RPY_ACCEPT    = 5'h03;
   localparam logic [4:0] RPY_REJECT    = 5'h04;
   localparam logic [4:0] RPY_REWORK    = 5'h05;
   localparam logic [4:0] RPY_SORT      = 5'h06;
   localparam logic [4:0] RPY_SHUTDOWN  = 5'h1F;
   localparam logic [4:0] RPY_CLASS_ERR = 5'h00;
   localparam logic [4:0] CLASS_MAX     = 5'h1E;
   localparam logic [1:0] STAT_ACCEPT   = 2'h0;
   localparam logic [1:0] STAT_REJECT   = 2'h1;
   localparam logic [1:0] STAT_REWORK   = 2'h2;
   localparam int CLK_MHZ      = 125;
   localparam int GAP_US       = 1000;
   localparam int GAP_CYC      = GAP_US * CLK_MHZ;
   localparam int SETUP_NS     = 80;
   localparam int SETUP_CYC    = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_CYC_DEF = 125000;
   typedef enum logic [1:0] {
      PGMP_TX_IDLE,
      PGMP_TX_SETUP,
      PGMP_TX_PULSE,
      PGMP_TX_GAP
   } pgmp_tx_st_t;
endpackage

// ---- pkg/pgmp_rpy_if.sv ----
// reply request channel between decoder and reply sender
`timescale 1ns/1ns
interface pgmp_rpy_if;
   logic       req;
   logic [4:0] code;
   logic       busy;
   modport src (output req, output code, input busy);
   modport snk (input req, input code, output busy);
endinterface

// ---- rtl/pgmp_msg_port.sv ----
// command decoder and reply sequencing for the gage message port
`timescale 1ns/1ns
module pgmp_msg_port #(
   parameter int PULSE_CYC = pgmp_pkg::PULSE_CYC_DEF,
   parameter int GAP_CYC   = pgmp_pkg::GAP_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [5:0] command_bits,
   input  wire logic       command_strobe_line,
   input  wire logic       fault_msg,
   input  wire logic       gage_done,
   input  wire logic [1:0] gage_status,
   input  wire logic       rr_study,
   input  wire logic       class_enable,
   input  wire logic [4:0] part_class,
   input  wire logic       adverse_event,
   output logic [4:0]      reply_code,
   output logic            reply_valid_line,
   output logic [1:0]      active_gage,
   output logic            gage_auto,
   output logic            gaging,
   output logic            end_gage_pulse,
   output logic            mastering,
   output logic            verifying,
   output logic [3:0]      feedback_clear,
   output logic [2:0]      machine_id,
   output logic [3:0]      setup_sel,
   output logic            position_reset
);
   import pgmp_pkg::*;
   typedef struct packed {
      logic       strb;
      logic       gaging;
      logic       auto;
      logic [1:0] gage;
      logic       mast;
      logic       ver;
      logic       endp;
      logic [3:0] fbclr;
      logic [2:0] mid;
      logic [3:0] setup;
      logic       posr;
      logic       class_pend;
      logic [4:0] class_val;
      logic       ack_pend;
      logic       shut_pend;
      logic       stat_pend;
      logic [4:0] stat_code;
      logic       adv;
      logic       flt;
   } pgmp_s_t;
   pgmp_s_t s_q, s_d;
   pgmp_rpy_if rpy ();
   logic [5:0] c;
   logic       rise;
   pgmp_reply_tx #(
      .PULSE_CYC (PULSE_CYC),
      .GAP_CYC   (GAP_CYC)
   ) u_tx (
      .core_clk         (core_clk),
      .reset            (reset),
      .rpy              (rpy.snk),
      .reply_code       (reply_code),
      .reply_valid_line (reply_valid_line)
   );
   assign c = command_bits;
   assign rise = command_strobe_line & ~s_q.strb;
   always_comb begin
      s_d            = s_q;
      s_d.strb       = command_strobe_line;
      s_d.adv        = adverse_event;
      s_d.flt        = fault_msg;
      s_d.endp       = 1'b0;
      s_d.fbclr      = 4'h0;
      s_d.posr       = 1'b0;
      rpy.req        = 1'b0;
      rpy.code       = 5'h00;
      // one reply at a time; shutdown first, class after status
      // served before new events so a same-cycle set wins
      if (!rpy.busy) begin
         if (s_q.shut_pend) begin
            rpy.req       = 1'b1;
            rpy.code      = RPY_SHUTDOWN;
            s_d.shut_pend = 1'b0;
         end else if (s_q.ack_pend) begin
            rpy.req      = 1'b1;
            rpy.code     = RPY_ACK;
            s_d.ack_pend = 1'b0;
         end else if (s_q.stat_pend) begin
            rpy.req       = 1'b1;
            rpy.code      = s_q.stat_code;
            s_d.stat_pend = 1'b0;
         end else if (s_q.class_pend) begin
            rpy.req        = 1'b1;
            rpy.code       = s_q.class_val;
            s_d.class_pend = 1'b0;
         end
      end
      if (rise) begin
         if (c >= CMD_START_LO && c <= CMD_START_HI) begin
            s_d.gaging = 1'b1;
            s_d.auto   = ~c[0];
            s_d.gage   = 2'((c - 6'h01) >> 1);
         end else if (c == CMD_END) begin
            s_d.endp = 1'b1;
         end else if (c >= CMD_MAST_LO && c <= CMD_MAST_HI) begin
            s_d.mast = 1'b1;
            s_d.gage = 2'(c - CMD_MAST_LO);
         end else if (c == CMD_ABORT) begin
            s_d.mast = 1'b0;
         end else if (c >= CMD_FB_LO && c <= CMD_FB_HI) begin
            s_d.fbclr = 4'h1 << 2'(c - CMD_FB_LO);
         end else if (c >= CMD_MID_LO && c <= CMD_MID_HI) begin
            s_d.mid = 3'(c - CMD_MID_LO);
         end else if (c >= CMD_POS_LO && c <= CMD_POS_HI) begin
            s_d.posr = 1'b1;
            s_d.gage = 2'(c - CMD_POS_LO);
         end else if (c >= CMD_VER_LO && c <= CMD_VER_HI) begin
            s_d.ver  = 1'b1;
            s_d.gage = 2'(c - CMD_VER_LO);
         end else if (c >= CMD_SETUP_LO && c <= CMD_SETUP_HI) begin
            s_d.setup = 4'(c - CMD_SETUP_LO);
         end
      end
      // gage completion queues replies
      if (gage_done && s_q.gaging) begin
         s_d.gaging    = 1'b0;
         s_d.stat_pend = 1'b1;
         if (!s_q.auto || s_q.mast) begin
            s_d.stat_code = RPY_END;
            s_d.mast      = 1'b0;
         end else if (rr_study) begin
            s_d.stat_code = RPY_SORT;
         end else begin
            case (gage_status)
               STAT_ACCEPT: s_d.stat_code = RPY_ACCEPT;
               STAT_REJECT: s_d.stat_code = RPY_REJECT;
               default:     s_d.stat_code = RPY_REWORK;
            endcase
         end
         if (s_q.auto && !s_q.mast && class_enable) begin
            s_d.class_pend = 1'b1;
            s_d.class_val  = (part_class == 5'h00 ||
                              part_class > CLASS_MAX)
                             ? RPY_CLASS_ERR : part_class;
         end
         s_d.ver = 1'b0;
      end
      if (fault_msg && !s_q.flt) begin
         s_d.ack_pend = 1'b1;
      end
      if (adverse_event && !s_q.adv) begin
         s_d.shut_pend = 1'b1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign active_gage    = s_q.gage;
   assign gage_auto      = s_q.auto;
   assign gaging         = s_q.gaging;
   assign end_gage_pulse = s_q.endp;
   assign mastering      = s_q.mast;
   assign verifying      = s_q.ver;
   assign feedback_clear = s_q.fbclr;
   assign machine_id     = s_q.mid;
   assign setup_sel      = s_q.setup;
   assign position_reset = s_q.posr;
endmodule

// ---- rtl/pgmp_reply_tx.sv ----
// reply sender: code setup, timed valid pulse, spacing gap
`timescale 1ns/1ns
module pgmp_reply_tx #(
   parameter int PULSE_CYC = pgmp_pkg::PULSE_CYC_DEF,
   parameter int GAP_CYC   = pgmp_pkg::GAP_CYC
) (
   input  wire logic         core_clk,
   input  wire logic         reset,
   pgmp_rpy_if.snk           rpy,
   output logic [4:0]        reply_code,
   output logic              reply_valid_line
);
   import pgmp_pkg::*;
   typedef struct packed {
      pgmp_tx_st_t st;
      logic [31:0] cnt;
      logic [4:0]  code;
      logic        vld;
   } pgmp_tx_s_t;
   pgmp_tx_s_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      case (s_q.st)
         PGMP_TX_IDLE: begin
            if (rpy.req) begin
               s_d.code = rpy.code;
               s_d.cnt  = 32'(SETUP_CYC);
               s_d.st   = PGMP_TX_SETUP;
            end
         end
         PGMP_TX_SETUP: begin
            s_d.cnt = s_q.cnt - 32'h1;
            if (s_q.cnt <= 32'h1) begin
               s_d.vld = 1'b1;
               s_d.cnt = 32'(PULSE_CYC);
               s_d.st  = PGMP_TX_PULSE;
            end
         end
         PGMP_TX_PULSE: begin
            s_d.cnt = s_q.cnt - 32'h1;
            if (s_q.cnt <= 32'h1) begin
               s_d.vld = 1'b0;
               s_d.cnt = 32'(GAP_CYC);
               s_d.st  = PGMP_TX_GAP;
            end
         end
         default: begin
            s_d.cnt = s_q.cnt - 32'h1;
            if (s_q.cnt <= 32'h1) begin
               s_d.st = PGMP_TX_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '{st: PGMP_TX_IDLE, cnt: 32'h0, code: 5'h00, vld: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
   assign rpy.busy         = (s_q.st != PGMP_TX_IDLE);
   assign reply_code       = s_q.code;
   assign reply_valid_line = s_q.vld;
endmodule
